// *** core/eod_pkg.sv ***
// Shared constants, opcode patterns and carrier types for the decode control block
package eod_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and depths
  localparam int PC_W = 15;
  localparam int DADDR_W = 16;
  localparam int PIN_DIR_N = 3;
  localparam int STACK_DEPTH = 16;
  localparam int STACK_AW = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Full opcodes
  localparam logic [13:0] OPC_RETURN = 14'h0008;
  localparam logic [13:0] OPC_RET_INT = 14'h0009;
  localparam logic [13:0] OPC_CALL_ACC = 14'h000A;
  localparam logic [13:0] OPC_BR_ACC = 14'h000B;
  localparam logic [13:0] OPC_OPTION = 14'h0062;
  localparam logic [13:0] OPC_SLEEP = 14'h0063;
  localparam logic [13:0] OPC_WDOG_CLR = 14'h0064;

  // Opcode prefixes, matched against the upper bits
  localparam logic [10:0] PFX_PIN_DIR = 11'h00C;
  localparam logic [10:0] PFX_LDINC = 11'h002;
  localparam logic [10:0] PFX_STINC = 11'h003;
  localparam logic [6:0] PFX_PTR_ADD = 7'h62;
  localparam logic [6:0] PFX_LDIDX = 7'h7E;
  localparam logic [6:0] PFX_STIDX = 7'h7F;
  localparam logic [5:0] PFX_RET_LIT = 6'h34;
  localparam logic [5:0] PFX_AND_LIT = 6'h39;
  localparam logic [5:0] PFX_ADD_LIT = 6'h3E;
  localparam logic [5:0] PFX_AND_FILE = 6'h05;
  localparam logic [4:0] PFX_BR_LIT = 5'h19;
  localparam logic [2:0] PFX_CALL = 3'h4;
  localparam logic [2:0] PFX_GOTO = 3'h5;
  localparam logic [3:0] PFX_SKIP_CLR = 4'h6;
  localparam logic [3:0] PFX_SKIP_SET = 4'h7;

  // First pin direction register index; lower codes are other inherent ops
  localparam logic [2:0] PIN_DIR_FIRST = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [PC_W-1:0] RST_PC = 15'h0000;
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [7:0] RST_PIN_DIR = 8'hFF;
  localparam logic [DADDR_W-1:0] RST_PTR = 16'h0000;
  localparam logic RST_SLEEP_FLAG = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {ST_RUN, ST_EXTRA, ST_FLUSH, ST_STANDBY} eod_state_e;

  typedef enum logic [4:0] {
    OP_NOP, OP_BR_ACC, OP_CALL_ACC, OP_RET, OP_RET_LIT, OP_OPTION, OP_SLEEP, OP_WDOG_CLR,
    OP_PIN_DIR, OP_PTR_ADD, OP_LDINC, OP_STINC, OP_LDIDX, OP_STIDX, OP_AND_LIT,
    OP_ADD_LIT, OP_AND_FILE, OP_BR_LIT, OP_CALL, OP_GOTO, OP_SKIP_CLR, OP_SKIP_SET
  } eod_op_e;

  typedef struct packed {
    logic carry;
    logic digit_carry;
    logic zero;
  } eod_status_s;

  localparam eod_status_s RST_STATUS = 3'h0;

endpackage

// *** core/eod_return_stack.sv ***
// Return address stack with registered top-of-stack read
`timescale 1ns/1ns
`default_nettype none
module eod_return_stack
  import eod_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic [PC_W-1:0] push_data_in,
  output logic [PC_W-1:0] top_out
);

  logic [PC_W-1:0] mem_ff [STACK_DEPTH];
  logic [STACK_AW-1:0] sp_ff;
  logic [PC_W-1:0] top_ff;

  // Storage array has no reset; only the pointer needs a known value
  always_ff @(posedge mclk_in) begin
    if (push_in) begin
      mem_ff[sp_ff] <= push_data_in;
    end
  end

  // Depth overflow wraps silently, overwriting the oldest entry
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sp_ff <= '0;
    end else if (push_in) begin
      sp_ff <= sp_ff + 4'h1;
    end else if (pop_in) begin
      sp_ff <= sp_ff - 4'h1;
    end
  end

  // Valid one clock after a push or pop settles
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      top_ff <= RST_PC;
    end else begin
      top_ff <= mem_ff[sp_ff - 4'h1];
    end
  end

  assign top_out = top_ff;

endmodule // eod_return_stack
`default_nettype wire

// *** core/eod_decode_ctrl.sv ***
// Instruction decode and execute control for branch, pointer and literal ops
//
// Notes on behaviour
// - PC change or true skip costs two cycles, second one a no-operation.
// - Indirect window access with effective address top bit set adds one cycle.
// - Relative branch by accumulator, two cycles, flags unchanged.
// - Call to accumulator target, two cycles, flags unchanged.
// - Return loading literal into accumulator, two cycles.
// - Accumulator copied to prescaler configuration, one cycle, flags kept.
// - Accumulator copied to selected pin direction register, one cycle.
// - Standby entry in one cycle, updating timeout and powerdown flags.
// - Pointer add with sign-extended six-bit literal, flags untouched.
// - Pointer arithmetic wraps modulo sixteen bits, no flag.
// - Load via pointer with pre/post step, zero flag updated.
// - Indexed load at pointer plus signed offset, zero updated.
// - Store via pointer with pre/post step, flags unchanged.
// - Indexed store at pointer plus signed offset, one cycle.
// - AND literal into accumulator, only zero updated.
// - Add literal into accumulator, carry, digit carry and zero updated.
// - AND with file, result to accumulator or file, zero updated.
`timescale 1ns/1ns
`default_nettype none
module eod_decode_ctrl
  import eod_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [13:0] instr_in,
  input wire logic [7:0] data_rdata_in,
  input wire logic wake_in,
  output logic [PC_W-1:0] pc_out,
  output logic phase_out,
  output logic [DADDR_W-1:0] data_addr_out,
  output logic data_we_out,
  output logic [7:0] data_wdata_out,
  output logic [7:0] acc_out,
  output eod_status_s status_out,
  output logic [7:0] option_out,
  output logic [PIN_DIR_N-1:0][7:0] pin_dir_out,
  output logic [1:0][DADDR_W-1:0] pointer_out,
  output logic standby_out,
  output logic timeout_flag_out,
  output logic powerdown_flag_out,
  output logic retire_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic wake_s1_ff, wake_s2_ff;
  eod_state_e st_ff, nxt_st;
  logic phase_ff, nxt_phase;
  logic [13:0] ir_ff;
  eod_op_e op_ff, cur_op;
  logic extra_ff, nxt_extra;
  logic [DADDR_W-1:0] addr_ff, ea, base, step;
  logic [DADDR_W-1:0] nptr_ff;
  logic nsel_ff, sel, ind;
  logic [PC_W-1:0] pc_ff, nxt_pc, stack_top;
  logic [7:0] acc_ff, nxt_acc, wdata_ff, nxt_wdata, andf;
  eod_status_s status_ff, nxt_status;
  logic [7:0] option_ff;
  logic [PIN_DIR_N-1:0][7:0] pin_dir_ff;
  logic [1:0][DADDR_W-1:0] ptr_ff;
  logic we_ff, standby_ff, tmo_ff, pwrdn_ff, retire_ff;
  logic capture, commit, flush, push, pop, store;
  logic [8:0] sum9;
  logic [4:0] nib;

  function automatic eod_op_e decode_op(input logic [13:0] i);
    eod_op_e o;
    o = OP_NOP;
    if (i == OPC_BR_ACC) o = OP_BR_ACC;
    else if (i == OPC_CALL_ACC) o = OP_CALL_ACC;
    else if (i == OPC_RETURN || i == OPC_RET_INT) o = OP_RET;
    else if (i == OPC_OPTION) o = OP_OPTION;
    else if (i == OPC_SLEEP) o = OP_SLEEP;
    else if (i == OPC_WDOG_CLR) o = OP_WDOG_CLR;
    else if (i[13:3] == PFX_PIN_DIR && i[2:0] >= PIN_DIR_FIRST) o = OP_PIN_DIR;
    else if (i[13:3] == PFX_LDINC) o = OP_LDINC;
    else if (i[13:3] == PFX_STINC) o = OP_STINC;
    else if (i[13:7] == PFX_PTR_ADD) o = OP_PTR_ADD;
    else if (i[13:7] == PFX_LDIDX) o = OP_LDIDX;
    else if (i[13:7] == PFX_STIDX) o = OP_STIDX;
    else if (i[13:8] == PFX_RET_LIT) o = OP_RET_LIT;
    else if (i[13:8] == PFX_AND_LIT) o = OP_AND_LIT;
    else if (i[13:8] == PFX_ADD_LIT) o = OP_ADD_LIT;
    else if (i[13:8] == PFX_AND_FILE) o = OP_AND_FILE;
    else if (i[13:9] == PFX_BR_LIT) o = OP_BR_LIT;
    else if (i[13:11] == PFX_CALL) o = OP_CALL;
    else if (i[13:11] == PFX_GOTO) o = OP_GOTO;
    else if (i[13:10] == PFX_SKIP_CLR) o = OP_SKIP_CLR;
    else if (i[13:10] == PFX_SKIP_SET) o = OP_SKIP_SET;
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Wake pin synchroniser
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_s1_ff <= 1'b0;
      wake_s2_ff <= 1'b0;
    end else begin
      wake_s1_ff <= wake_in;
      wake_s2_ff <= wake_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: each instruction cycle is two clocks, fetch then commit
  assign capture = (st_ff == ST_RUN) && !phase_ff;
  assign commit = phase_ff && ((st_ff == ST_RUN && !extra_ff) || st_ff == ST_EXTRA);

  always_comb begin
    nxt_st = st_ff;
    nxt_phase = !phase_ff;
    case (st_ff)
      ST_RUN: begin
        if (phase_ff) begin
          if (extra_ff) nxt_st = ST_EXTRA;
          else if (op_ff == OP_SLEEP) nxt_st = ST_STANDBY;
          else if (flush) nxt_st = ST_FLUSH;
        end
      end
      ST_EXTRA: begin
        if (phase_ff) nxt_st = flush ? ST_FLUSH : ST_RUN;
      end
      ST_FLUSH: begin
        if (phase_ff) nxt_st = ST_RUN;
      end
      ST_STANDBY: begin
        nxt_phase = 1'b0;
        if (wake_s2_ff) nxt_st = ST_RUN;
      end
      default: nxt_st = ST_RUN;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= ST_RUN;
      phase_ff <= 1'b0;
      standby_ff <= 1'b0;
      retire_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      phase_ff <= nxt_phase;
      standby_ff <= (nxt_st == ST_STANDBY);
      retire_ff <= commit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch phase: decode and form the data address
  always_comb begin
    cur_op = decode_op(instr_in);
    if (cur_op == OP_LDIDX || cur_op == OP_STIDX) sel = instr_in[6];
    else if (cur_op == OP_LDINC || cur_op == OP_STINC) sel = instr_in[2];
    else sel = instr_in[0];
    base = ptr_ff[sel];
    // Pre and post forms both leave the pointer stepped
    step = instr_in[0] ? base - 16'h0001 : base + 16'h0001;
    ea = {9'h000, instr_in[6:0]};
    ind = 1'b0;
    case (cur_op)
      OP_LDINC, OP_STINC: begin
        ea = instr_in[1] ? base : step;
        ind = 1'b1;
      end
      OP_LDIDX, OP_STIDX: begin
        ea = base + {{10{instr_in[5]}}, instr_in[5:0]};
        ind = 1'b1;
      end
      OP_AND_FILE, OP_SKIP_CLR, OP_SKIP_SET: begin
        if (instr_in[6:1] == 6'h00) begin
          ea = base;
          ind = 1'b1;
        end
      end
      default: ;
    endcase
    nxt_extra = ind && ea[15];
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ir_ff <= 14'h0000;
      op_ff <= OP_NOP;
      extra_ff <= 1'b0;
      addr_ff <= RST_PTR;
      nptr_ff <= RST_PTR;
      nsel_ff <= 1'b0;
    end else if (capture) begin
      ir_ff <= instr_in;
      op_ff <= cur_op;
      extra_ff <= nxt_extra;
      addr_ff <= ea;
      nptr_ff <= step;
      nsel_ff <= sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commit phase: results, flags and next program counter
  always_comb begin
    nxt_pc = pc_ff + 15'h0001;
    nxt_acc = acc_ff;
    nxt_status = status_ff;
    nxt_wdata = acc_ff;
    flush = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    store = 1'b0;
    sum9 = {1'b0, acc_ff} + {1'b0, ir_ff[7:0]};
    nib = {1'b0, acc_ff[3:0]} + {1'b0, ir_ff[3:0]};
    andf = acc_ff & data_rdata_in;
    case (op_ff)
      OP_BR_ACC: begin
        nxt_pc = pc_ff + 15'h0001 + {7'h00, acc_ff};
        flush = 1'b1;
      end
      OP_CALL_ACC: begin
        nxt_pc = {pc_ff[14:8], acc_ff};
        push = 1'b1;
        flush = 1'b1;
      end
      OP_RET: begin
        nxt_pc = stack_top;
        pop = 1'b1;
        flush = 1'b1;
      end
      OP_RET_LIT: begin
        nxt_pc = stack_top;
        nxt_acc = ir_ff[7:0];
        pop = 1'b1;
        flush = 1'b1;
      end
      OP_BR_LIT: begin
        nxt_pc = pc_ff + 15'h0001 + {{6{ir_ff[8]}}, ir_ff[8:0]};
        flush = 1'b1;
      end
      OP_CALL, OP_GOTO: begin
        nxt_pc = {pc_ff[14:11], ir_ff[10:0]};
        push = (op_ff == OP_CALL);
        flush = 1'b1;
      end
      OP_LDINC, OP_LDIDX: begin
        nxt_acc = data_rdata_in;
        nxt_status.zero = (data_rdata_in == 8'h00);
      end
      OP_STINC, OP_STIDX: store = 1'b1;
      OP_AND_LIT: begin
        nxt_acc = acc_ff & ir_ff[7:0];
        nxt_status.zero = ((acc_ff & ir_ff[7:0]) == 8'h00);
      end
      OP_ADD_LIT: begin
        nxt_acc = sum9[7:0];
        nxt_status.carry = sum9[8];
        nxt_status.digit_carry = nib[4];
        nxt_status.zero = (sum9[7:0] == 8'h00);
      end
      OP_AND_FILE: begin
        nxt_status.zero = (andf == 8'h00);
        nxt_wdata = andf;
        if (ir_ff[7]) store = 1'b1;
        else nxt_acc = andf;
      end
      OP_SKIP_CLR, OP_SKIP_SET: begin
        if (data_rdata_in[ir_ff[9:7]] == (op_ff == OP_SKIP_SET)) begin
          nxt_pc = pc_ff + 15'h0002;
          flush = 1'b1;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_ff <= RST_PC;
      acc_ff <= RST_ACC;
      status_ff <= RST_STATUS;
    end else if (commit) begin
      pc_ff <= nxt_pc;
      acc_ff <= nxt_acc;
      status_ff <= nxt_status;
    end
  end

  // Write strobe stands the clock after commit, while the address still holds
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      we_ff <= 1'b0;
      wdata_ff <= 8'h00;
    end else begin
      we_ff <= commit && store;
      if (commit) wdata_ff <= nxt_wdata;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      option_ff <= RST_OPTION;
      tmo_ff <= RST_SLEEP_FLAG;
      pwrdn_ff <= RST_SLEEP_FLAG;
    end else if (commit) begin
      if (op_ff == OP_OPTION) option_ff <= acc_ff;
      if (op_ff == OP_SLEEP) begin
        tmo_ff <= 1'b1;
        pwrdn_ff <= 1'b0;
      end else if (op_ff == OP_WDOG_CLR) begin
        tmo_ff <= 1'b1;
        pwrdn_ff <= 1'b1;
      end
    end
  end

  for (genvar g = 0; g < PIN_DIR_N; g++) begin : g_pin_dir
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        pin_dir_ff[g] <= RST_PIN_DIR;
      end else if (commit && op_ff == OP_PIN_DIR && ir_ff[2:0] == PIN_DIR_FIRST + 3'(g)) begin
        pin_dir_ff[g] <= acc_ff;
      end
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_ptr
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        ptr_ff[g] <= RST_PTR;
      end else if (commit && op_ff == OP_PTR_ADD && ir_ff[6] == 1'(g)) begin
        ptr_ff[g] <= ptr_ff[g] + {{10{ir_ff[5]}}, ir_ff[5:0]};
      end else if (commit && (op_ff == OP_LDINC || op_ff == OP_STINC) && nsel_ff == 1'(g)) begin
        ptr_ff[g] <= nptr_ff;
      end
    end
  end

  eod_return_stack u_stack (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .push_in(commit && push),
    .pop_in(commit && pop),
    .push_data_in(pc_ff + 15'h0001),
    .top_out(stack_top)
  );

  assign pc_out = pc_ff;
  assign phase_out = phase_ff;
  assign data_addr_out = addr_ff;
  assign data_we_out = we_ff;
  assign data_wdata_out = wdata_ff;
  assign acc_out = acc_ff;
  assign status_out = status_ff;
  assign option_out = option_ff;
  assign pin_dir_out = pin_dir_ff;
  assign pointer_out = ptr_ff;
  assign standby_out = standby_ff;
  assign timeout_flag_out = tmo_ff;
  assign powerdown_flag_out = pwrdn_ff;
  assign retire_out = retire_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  property p_flush_cycle;
    commit && flush |=> (st_ff == ST_FLUSH)[*2] ##1 (st_ff == ST_RUN);
  endproperty
  a_flush_cycle: assert property (p_flush_cycle) else $error("no flush cycle");

  property p_extra_cycle;
    capture && nxt_extra |=> ##1 (st_ff == ST_EXTRA && !retire_out)[*2] ##1 retire_out;
  endproperty
  a_extra_cycle: assert property (p_extra_cycle) else $error("no extra cycle");

  property p_br_acc;
    commit && op_ff == OP_BR_ACC |=> pc_ff == 15'($past(pc_ff) + 15'h0001 + {7'h00, $past(acc_ff)})
      && status_ff == $past(status_ff);
  endproperty
  a_br_acc: assert property (p_br_acc) else $error("relative branch target wrong");

  property p_call_acc;
    commit && op_ff == OP_CALL_ACC |=> pc_ff[7:0] == $past(acc_ff) && status_ff == $past(status_ff);
  endproperty
  a_call_acc: assert property (p_call_acc) else $error("call via acc wrong");

  property p_ret_lit;
    commit && op_ff == OP_RET_LIT |=> acc_out == $past(ir_ff[7:0]) && st_ff == ST_FLUSH;
  endproperty
  a_ret_lit: assert property (p_ret_lit) else $error("literal return wrong");

  property p_option;
    commit && op_ff == OP_OPTION |=> option_out == $past(acc_ff) && status_ff == $past(status_ff);
  endproperty
  a_option: assert property (p_option) else $error("option load wrong");

  property p_sleep;
    commit && op_ff == OP_SLEEP |=> standby_out && timeout_flag_out && !powerdown_flag_out;
  endproperty
  a_sleep: assert property (p_sleep) else $error("standby entry wrong");

  property p_ptr_add;
    commit && op_ff == OP_PTR_ADD && !ir_ff[6] |=>
      pointer_out[0] == 16'($past(ptr_ff[0]) + {{10{$past(ir_ff[5])}}, $past(ir_ff[5:0])});
  endproperty
  a_ptr_add: assert property (p_ptr_add) else $error("pointer add wrong");

  property p_and_lit;
    commit && op_ff == OP_AND_LIT |=> status_out.zero == (acc_out == 8'h00)
      && status_out.carry == $past(status_ff.carry);
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("and literal flags wrong");

  property p_and_file;
    commit && op_ff == OP_AND_FILE && ir_ff[7] |=> data_we_out
      && data_wdata_out == $past(acc_ff & data_rdata_in) && acc_out == $past(acc_ff);
  endproperty
  a_and_file: assert property (p_and_file) else $error("and to file wrong");

  property p_unknown_nop;
    commit && op_ff == OP_NOP |=> pc_ff == 15'($past(pc_ff) + 15'h0001) && st_ff == ST_RUN;
  endproperty
  a_unknown_nop: assert property (p_unknown_nop) else $error("unknown op not a nop");

  c_br_acc: cover property (commit && op_ff == OP_BR_ACC);
  c_extra: cover property (st_ff == ST_EXTRA && commit);
  c_standby: cover property (standby_out ##1 !standby_out);
  c_store: cover property (data_we_out);

endmodule // eod_decode_ctrl
`default_nettype wire

// *** verification/eod_mem_model.sv ***
// Program and data memory model facing the decode control block
`timescale 1ns/1ns
`default_nettype none
module eod_mem_model
  import eod_pkg::*;
(
  input wire logic mclk_in,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [DADDR_W-1:0] addr_in,
  input wire logic we_in,
  input wire logic [7:0] wdata_in,
  output logic [13:0] instr_out,
  output logic [7:0] rdata_out
);
  logic [13:0] prog [0:255];
  logic [7:0] dmem [0:65535];
  ////////////////////////////////////////////////////////////////////////////
  // Fill from the low address byte, so a read with the wrong low byte gives a wrong value
  initial begin
    for (int i = 0; i < 65536; i++) begin
      dmem[i] = 8'(i) ^ 8'hA5;
    end
  end
  // Program space is small; upper program counter bits alias
  assign instr_out = prog[pc_in[7:0]];
  assign rdata_out = dmem[addr_in];
  always @(posedge mclk_in) begin
    if (we_in === 1'b1) begin
      dmem[addr_in] <= wdata_in;
    end
  end
endmodule // eod_mem_model
`default_nettype wire

// *** verification/test_enhanced_op_decode_control.sv ***
// Self-checking bench for the decode control block
`timescale 1ns/1ns
`default_nettype none
module test_enhanced_op_decode_control;
  import eod_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wake_in = 1'b0;
  logic [13:0] instr_in;
  logic [7:0] data_rdata_in;
  logic [PC_W-1:0] pc_out;
  logic phase_out;
  logic data_we_out;
  logic standby_out;
  logic timeout_flag_out;
  logic powerdown_flag_out;
  logic retire_out;
  logic [DADDR_W-1:0] data_addr_out;
  logic [7:0] data_wdata_out;
  logic [7:0] acc_out;
  logic [7:0] option_out;
  eod_status_s status_out;
  logic [PIN_DIR_N-1:0][7:0] pin_dir_out;
  logic [1:0][DADDR_W-1:0] pointer_out;
  int fail_count = 0;
  int comparisons = 0;
  int clk_count = 0;
  int retires = 0;
  always #20 mclk_in = ~mclk_in;
  // Clocks since reset release; one instruction cycle is two of them
  always @(posedge mclk_in) begin
    clk_count <= rst_n_in ? clk_count + 1 : 0;
  end
  eod_decode_ctrl u_dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .instr_in(instr_in),
    .data_rdata_in(data_rdata_in), .wake_in(wake_in), .pc_out(pc_out),
    .phase_out(phase_out), .data_addr_out(data_addr_out), .data_we_out(data_we_out),
    .data_wdata_out(data_wdata_out), .acc_out(acc_out), .status_out(status_out),
    .option_out(option_out), .pin_dir_out(pin_dir_out), .pointer_out(pointer_out),
    .standby_out(standby_out), .timeout_flag_out(timeout_flag_out),
    .powerdown_flag_out(powerdown_flag_out), .retire_out(retire_out)
  );
  eod_mem_model u_mem (
    .mclk_in(mclk_in), .pc_in(pc_out), .addr_in(data_addr_out), .we_in(data_we_out),
    .wdata_in(data_wdata_out), .instr_out(instr_in), .rdata_out(data_rdata_in)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic ck_as(input logic [7:0] a, input logic [2:0] s);
    check("acc_status", 32'({acc_out, status_out}), 32'({a, s}));
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Unwritten program words stay plain no-operations
  task automatic restart();
    for (int i = 0; i < 256; i++) begin
      u_mem.prog[i] = 14'h0000;
    end
    @(negedge mclk_in);
    rst_n_in = 1'b0;
    retires = 0;
    repeat (20) @(negedge mclk_in);
  endtask
  // Runs to the n-th retire since release; a negative clock figure is not compared
  task automatic run_to(input int n, input int exp_clk);
    int guard = 0;
    rst_n_in = 1'b1;
    while (retires < n && guard < 200) begin
      @(negedge mclk_in);
      guard++;
      if (retire_out === 1'b1) begin
        retires++;
      end
    end
    check("retires", 32'(retires), 32'(n));
    if (exp_clk >= 0) begin
      check("clocks", 32'(clk_count), 32'(exp_clk));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_literal();
    restart();
    check("flags_rst", 32'({timeout_flag_out, powerdown_flag_out}), 32'h3);
    check("pin_rst", 32'({pin_dir_out, option_out}), 32'hFFFFFFFF);
    u_mem.prog[0] = 14'h3E8F;
    u_mem.prog[1] = 14'h3E71;
    u_mem.prog[2] = 14'h390F;
    u_mem.prog[3] = 14'h3E3C;
    u_mem.prog[4] = 14'h0062;
    u_mem.prog[5] = 14'h0065;
    u_mem.prog[6] = 14'h0067;
    u_mem.prog[7] = 14'h39C3;
    run_to(1, 2);
    ck_as(8'h8F, 3'b000);
    run_to(2, 4);
    ck_as(8'h00, 3'b111);
    run_to(3, 6);
    ck_as(8'h00, 3'b111);
    run_to(5, 10);
    check("option", 32'(option_out), 32'h3C);
    ck_as(8'h3C, 3'b000);
    run_to(7, 14);
    check("pin_dir", 32'(pin_dir_out), 32'h3CFF3C);
    run_to(8, 16);
    ck_as(8'h00, 3'b001);
  endtask
  task automatic test_control();
    restart();
    u_mem.prog[0] = 14'h3E02;
    u_mem.prog[1] = 14'h000B;
    u_mem.prog[2] = 14'h3E40;
    u_mem.prog[3] = 14'h3E40;
    u_mem.prog[4] = 14'h3E0E;
    u_mem.prog[5] = 14'h000A;
    u_mem.prog[6] = 14'h3202;
    u_mem.prog[7] = 14'h3E40;
    u_mem.prog[8] = 14'h3E40;
    u_mem.prog[9] = 14'h2820;
    u_mem.prog[16] = 14'h3455;
    u_mem.prog[32] = 14'h2030;
    u_mem.prog[33] = 14'h1821;
    u_mem.prog[34] = 14'h3E40;
    u_mem.prog[35] = 14'h1C21;
    u_mem.prog[36] = 14'h3E01;
    u_mem.prog[37] = 14'h0001;
    u_mem.prog[48] = 14'h0008;
    run_to(5, 14);
    ck_as(8'h55, 3'b010);
    run_to(9, 30);
    ck_as(8'h55, 3'b010);
    run_to(10, 34);
    run_to(11, 38);
    run_to(12, 40);
    ck_as(8'h56, 3'b000);
    run_to(13, 42);
    check("pc", 32'(pc_out), 32'h26);
  endtask
  task automatic test_pointer();
    restart();
    u_mem.prog[0] = 14'h313F;
    u_mem.prog[1] = 14'h315F;
    u_mem.prog[2] = 14'h3160;
    u_mem.prog[3] = 14'h3E5A;
    u_mem.prog[4] = 14'h0018;
    u_mem.prog[5] = 14'h001F;
    u_mem.prog[6] = 14'h3900;
    u_mem.prog[7] = 14'h0012;
    u_mem.prog[8] = 14'h3F41;
    u_mem.prog[9] = 14'h3F04;
    u_mem.prog[10] = 14'h3FBF;
    u_mem.prog[11] = 14'h0590;
    u_mem.prog[12] = 14'h0525;
    run_to(1, 2);
    check("ptr", 32'(pointer_out), 32'h0000FFFF);
    run_to(3, 6);
    check("ptr", 32'(pointer_out), 32'hFFFFFFFF);
    ck_as(8'h00, 3'b000);
    run_to(6, 14);
    check("ptr", 32'(pointer_out), 32'hFFFE0000);
    run_to(8, 18);
    check("mem_lo", 32'(u_mem.dmem[0]), 32'h5A);
    check("mem_hi", 32'(u_mem.dmem[65535]), 32'h5A);
    ck_as(8'h5A, 3'b000);
    check("ptr0", 32'(pointer_out[0]), 32'h0001);
    run_to(9, 22);
    run_to(10, 24);
    ck_as(8'hA0, 3'b000);
    check("addr_phase", 32'({data_addr_out, phase_out}), 32'h0000000A);
    run_to(12, 28);
    check("store", 32'({data_we_out, data_wdata_out, data_addr_out}), 32'h01A00010);
    run_to(13, 30);
    check("mem_idx", 32'(u_mem.dmem[0]), 32'hA0);
    check("mem_file", 32'(u_mem.dmem[16]), 32'hA0);
    ck_as(8'h80, 3'b000);
    check("wdata", 32'({data_we_out, data_wdata_out}), 32'h00000080);
  endtask
  task automatic test_standby();
    restart();
    u_mem.prog[0] = 14'h0063;
    u_mem.prog[1] = 14'h0064;
    run_to(1, 2);
    check("sleep", 32'({standby_out, timeout_flag_out, powerdown_flag_out}), 32'h6);
    repeat (10) @(negedge mclk_in);
    check("asleep", 32'({standby_out, phase_out}), 32'h2);
    wake_in = 1'b1;
    run_to(2, -1);
    check("awake", 32'({standby_out, timeout_flag_out, powerdown_flag_out}), 32'h3);
    wake_in = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    test_literal();
    test_control();
    test_pointer();
    test_standby();
    report_and_stop();
  end
  // Whole run is about two hundred clocks; this limit leaves wide margin
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
endmodule // test_enhanced_op_decode_control
`default_nettype wire
